// [common/acr_pkg.sv]
// Purpose: Constants for the channel routing and setup configuration register bank
// Assumes: APB slave, 32-bit data, word-aligned registers
package acr_pkg;
	// ----------------------------------------
	// Register map (printed offsets are indexes)
	// ----------------------------------------
	localparam logic [7:0]  CHAN_BASE_IDX  = 8'h10;
	localparam logic [7:0]  SETUP_BASE_IDX = 8'h20;
	localparam logic [7:0]  SETUP_LAST_IDX = 8'h27;
	localparam logic [7:0]  STATUS_IDX     = 8'h30;
	localparam int          NUM_CHAN       = 16;
	localparam int          NUM_SETUP      = 8;
	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [15:0] CHAN_RESET     = 16'h8001;
	localparam logic [15:0] CHAN_WMASK     = 16'hf3ff;
	localparam logic [15:0] SETUP_RESET    = 16'h1000;
	localparam logic [15:0] SETUP_WMASK    = 16'h1f30;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          CH_ON_BIT      = 15;
	localparam int          PICK_LSB       = 12;
	localparam int          CODING_BIT     = 12;
	localparam int          POS_BUF_BIT    = 11;
	localparam int          NEG_BUF_BIT    = 10;
	localparam int          INBUF_LSB      = 8;
	localparam int          REFSEL_LSB     = 4;
	// ----------------------------------------
	// Input selector codes
	// ----------------------------------------
	localparam logic [9:0]  SEL_TEMP       = 10'h232;
	localparam logic [9:0]  SEL_REF        = 10'h2b6;
	localparam logic [4:0]  SEL_COMMON     = 5'h10;
	// ----------------------------------------
	// Routing kinds and enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		ROUTE_NONE = 3'b000,
		ROUTE_DIFF = 3'b001,
		ROUTE_SE   = 3'b010,
		ROUTE_TEMP = 3'b011,
		ROUTE_REF  = 3'b100
	} acr_route_t;
	typedef enum logic [1:0] {
		REF_EXT    = 2'b00,
		REF_RSVD   = 2'b01,
		REF_INT    = 2'b10,
		REF_SUPPLY = 2'b11
	} acr_ref_t;
endpackage

// [design/acr_route_decode.sv]
// Purpose: Decode an input-pair selector code into routed inputs
// Assumes: Codes as in the selector table; anything else is unrouted
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module acr_route_decode (
	// Selector
	input  wire logic [9:0]  sel,
	// Decoded route
	output logic [2:0]       kind,
	output logic [3:0]       pos_in,
	output logic [3:0]       neg_in
);
	wire logic [3:0] p       = sel[8:5];
	wire logic [3:0] n       = sel[3:0];
	wire logic       is_se   = (sel[9] == 1'b0) && (sel[4:0] == acr_pkg::SEL_COMMON);
	// Differential legal only for neighbours within one pair
	wire logic       is_diff = (sel[9] == 1'b0) && (sel[4] == 1'b0)
		&& (p[3:1] == n[3:1]) && (p[0] != n[0]);
	always_comb begin
		kind   = acr_pkg::ROUTE_NONE;
		pos_in = 4'h0;
		neg_in = 4'h0;
		if (sel == acr_pkg::SEL_TEMP) begin
			kind = acr_pkg::ROUTE_TEMP;
		end else if (sel == acr_pkg::SEL_REF) begin
			kind = acr_pkg::ROUTE_REF;
		end else if (is_se) begin
			kind   = acr_pkg::ROUTE_SE;
			pos_in = p;
		end else if (is_diff) begin
			kind   = acr_pkg::ROUTE_DIFF;
			pos_in = p;
			neg_in = n;
		end
	end
endmodule
`default_nettype wire

// [design/acr_regs.sv]
// Purpose: Channel routing and setup configuration register bank on APB
// Assumes: Single clock, zero wait-state APB slave
// Notes: Presents the active channel's routing and setup to the converter
`timescale 1ns/1ps
`default_nettype none
module acr_regs (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Converter side
	input  wire logic        CONV_DONE,
	output logic [3:0]       ACTIVE_CHAN,
	output logic             ANY_ON,
	output logic [2:0]       ROUTE_KIND,
	output logic [3:0]       ROUTE_POS,
	output logic [3:0]       ROUTE_NEG,
	output logic             OUTPUT_CODING_SEL,
	output logic             POS_REF_BUFFER_EN,
	output logic             NEG_REF_BUFFER_EN,
	output logic             ANALOG_INPUT_BUFFER_EN,
	output logic [1:0]       REFERENCE_SOURCE_SEL
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0] chan_reg [acr_pkg::NUM_CHAN];
	logic [15:0] setup_reg [acr_pkg::NUM_SETUP];
	logic [3:0]  cur;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic [7:0] idx     = PADDR[9:2];
	wire logic       aligned = (PADDR[1:0] == 2'b00) && (PADDR[11:10] == 2'b00);
	wire logic       hit_ch  = aligned && (idx[7:4] == acr_pkg::CHAN_BASE_IDX[7:4]);
	wire logic       hit_su  = aligned && (idx[7:3] == acr_pkg::SETUP_BASE_IDX[7:3]);
	wire logic       hit_st  = aligned && (idx == acr_pkg::STATUS_IDX);
	wire logic       mapped  = hit_ch || hit_su || hit_st;
	wire logic       setup_ph = PSEL && !PENABLE;
	wire logic       wr_ch   = setup_ph && PWRITE && hit_ch;
	wire logic       wr_su   = setup_ph && PWRITE && hit_su;

	// ----------------------------------------
	// Sequencer: next enabled channel after cur
	// ----------------------------------------
	function automatic logic [3:0] next_on(input logic [3:0] from, input logic [15:0] on);
		logic [3:0] r;
		logic [4:0] k;
		logic [3:0] c;
		r = from;
		for (int i = 16; i >= 1; i--) begin
			k = 5'(from) + 5'(i);
			c = k[3:0];
			if (on[c]) begin
				r = c;
			end
		end
		return r;
	endfunction

	logic [15:0] on_vec;
	genvar g;
	generate
		for (g = 0; g < acr_pkg::NUM_CHAN; g++) begin : g_on
			assign on_vec[g] = chan_reg[g][acr_pkg::CH_ON_BIT];
		end
	endgenerate

	wire logic [3:0] next_cur = next_on(cur, on_vec);
	wire logic       cur_off  = !on_vec[cur];

	// ----------------------------------------
	// Active channel's setup and route
	// ----------------------------------------
	wire logic [15:0] act_ch   = chan_reg[cur];
	wire logic [2:0]  pick     = act_ch[acr_pkg::PICK_LSB +: 3];
	wire logic [15:0] act_su   = setup_reg[pick];
	logic [2:0] dec_kind;
	logic [3:0] dec_pos;
	logic [3:0] dec_neg;

	acr_route_decode i_acr_route_decode (
		.sel    (act_ch[9:0]),
		.kind   (dec_kind),
		.pos_in (dec_pos),
		.neg_in (dec_neg)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire logic [15:0] status_word = {11'h000, (on_vec != 16'h0000), cur};
	wire logic [15:0] rd_word =
		hit_ch ? chan_reg[idx[3:0]] :
		hit_su ? setup_reg[idx[2:0]] :
		hit_st ? status_word : 16'h0000;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	generate
		for (g = 0; g < acr_pkg::NUM_CHAN; g++) begin : g_ch
			always_ff @(posedge CORE_CLK or negedge RST_N) begin
				if (!RST_N) begin
					chan_reg[g] <= acr_pkg::CHAN_RESET;
				end else if (wr_ch && idx[3:0] == 4'(g)) begin
					chan_reg[g] <= PWDATA[15:0] & acr_pkg::CHAN_WMASK;
				end
			end
		end
		for (g = 0; g < acr_pkg::NUM_SETUP; g++) begin : g_su
			always_ff @(posedge CORE_CLK or negedge RST_N) begin
				if (!RST_N) begin
					setup_reg[g] <= acr_pkg::SETUP_RESET;
				end else if (wr_su && idx[2:0] == 3'(g)) begin
					// Reserved bits never stored, so they read zero
					setup_reg[g] <= PWDATA[15:0] & acr_pkg::SETUP_WMASK;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cur <= 4'h0;
		end else if (CONV_DONE || cur_off) begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Bus answer, one access cycle
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup_ph;
			PSLVERR <= setup_ph && !mapped;
			if (setup_ph && !PWRITE) begin
				PRDATA <= {16'h0000, rd_word};
			end
		end
	end

	// ----------------------------------------
	// Converter-facing outputs, registered
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACTIVE_CHAN            <= 4'h0;
			ANY_ON                 <= 1'b0;
			ROUTE_KIND             <= 3'b000;
			ROUTE_POS              <= 4'h0;
			ROUTE_NEG              <= 4'h0;
			OUTPUT_CODING_SEL      <= 1'b0;
			POS_REF_BUFFER_EN      <= 1'b0;
			NEG_REF_BUFFER_EN      <= 1'b0;
			ANALOG_INPUT_BUFFER_EN <= 1'b0;
			REFERENCE_SOURCE_SEL   <= 2'b00;
		end else begin
			ACTIVE_CHAN            <= cur;
			ANY_ON                 <= (on_vec != 16'h0000);
			ROUTE_KIND             <= dec_kind;
			ROUTE_POS              <= dec_pos;
			ROUTE_NEG              <= dec_neg;
			OUTPUT_CODING_SEL      <= act_su[acr_pkg::CODING_BIT];
			POS_REF_BUFFER_EN      <= act_su[acr_pkg::POS_BUF_BIT];
			NEG_REF_BUFFER_EN      <= act_su[acr_pkg::NEG_BUF_BIT];
			// Reserved mixed codes treated as off: safer than half-enabled
			ANALOG_INPUT_BUFFER_EN <= (act_su[acr_pkg::INBUF_LSB +: 2] == 2'b11);
			REFERENCE_SOURCE_SEL   <= act_su[acr_pkg::REFSEL_LSB +: 2];
		end
	end
endmodule
`default_nettype wire

// [sim/acr_regs_asserts.sv]
// Purpose: Port-level checks for acr_regs
// Assumes: Zero wait-state APB slave
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module acr_regs_asserts (
	// Clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST_N,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Converter side
	input wire logic        ANY_ON,
	input wire logic        OUTPUT_CODING_SEL,
	input wire logic [2:0]  ROUTE_KIND,
	input wire logic [3:0]  ROUTE_NEG
);
	// ----
	// Decode
	// ----
	wire logic [7:0] idx     = PADDR[9:2];
	wire logic       aligned = PADDR[1:0] == 2'b00 && PADDR[11:10] == 2'b00;
	wire logic       is_ch   = aligned && idx[7:4] == 4'h1;
	wire logic       is_su   = aligned && idx[7:3] == 5'h04;
	wire logic       mapped  = is_ch || is_su || (aligned && idx == 8'h30);
	wire logic       rd_ok   = PREADY && !PWRITE && !PSLVERR;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// ----
	// Checks
	// ----
	property p_ready_next; PSEL && !PENABLE |=> PREADY; endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
	property p_ready_pulse; PREADY |=> !PREADY; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_err_ready; PSLVERR |-> PREADY; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_unmapped; PSEL && !PENABLE && !PWRITE && !mapped |=> PSLVERR && PRDATA == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
	property p_rsvd_su; rd_ok && is_su |-> (PRDATA & 32'hffffe0cf) == 32'h0; endproperty
	a_rsvd_su: assert property (p_rsvd_su) else $error("setup reserved bits set");
	property p_rsvd_ch; rd_ok && is_ch |-> (PRDATA & 32'hffff0c00) == 32'h0; endproperty
	a_rsvd_ch: assert property (p_rsvd_ch) else $error("channel reserved bits set");
	property p_reset; $rose(RST_N) |=> ROUTE_KIND == 3'h1 && ANY_ON && OUTPUT_CODING_SEL; endproperty
	a_reset: assert property (p_reset) else $error("bad outputs after reset");
	property p_single_neg; ROUTE_KIND > 3'h1 |-> ROUTE_NEG == 4'h0; endproperty
	a_single_neg: assert property (p_single_neg) else $error("negative input set");
endmodule
bind acr_regs acr_regs_asserts i_acr_regs_asserts (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .ANY_ON(ANY_ON), .OUTPUT_CODING_SEL(OUTPUT_CODING_SEL),
	.ROUTE_KIND(ROUTE_KIND), .ROUTE_NEG(ROUTE_NEG));
`default_nettype wire

// [sim/acr_regs_tb.sv]
// Purpose: Self-checking bench for acr_regs
// Assumes: APB master waits for ready; 50 ns clock
// Notes: Converter outputs are sampled on the falling edge, away from updates; bus answers are sampled at rising edges
`timescale 1ns/1ps
`default_nettype none
module acr_regs_tb;
	// ----
	// Signals
	// ----
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel  = 1'b0;
	logic        pen   = 1'b0;
	logic        pwr   = 1'b0;
	logic [11:0] pa    = 12'h0;
	logic [31:0] pwd   = 32'h0;
	logic        done  = 1'b0;
	logic [31:0] rd;
	logic        re;
	int          fail_count  = 0;
	int          comparisons = 0;
	// Legal software codes only; internal reference assumed enabled in mode register
	logic [15:0] sw [5] = '{16'h1f30, 16'h0320, 16'h1300, 16'h0400, 16'h1800};
	logic [5:0]  sf [5] = '{6'h3f, 6'h06, 6'h24, 6'h08, 6'h30};
	// Unlisted code first: stored but routes nothing
	logic [9:0]  rc [8] = '{10'h044, 10'h001, 10'h043, 10'h062, 10'h050, 10'h1f0, 10'h232,
		10'h2b6};
	logic [10:0] rk [8] = '{11'h000, 11'h101, 11'h123, 11'h132, 11'h220, 11'h2f0, 11'h300,
		11'h400};
	wire logic [31:0] prd;
	wire logic        rdy, err, any, cod, pbuf, nbuf, ibuf;
	wire logic [3:0]  chan, rpos, rneg;
	wire logic [2:0]  kind;
	wire logic [1:0]  rsel;
	wire logic [31:0] ov = {10'h0, chan, any, kind, rpos, rneg, cod, pbuf, nbuf, ibuf, rsel};
	always #25 clk = ~clk;
	acr_regs i_acr_regs (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
		.CONV_DONE(done), .ACTIVE_CHAN(chan), .ANY_ON(any), .ROUTE_KIND(kind),
		.ROUTE_POS(rpos), .ROUTE_NEG(rneg), .OUTPUT_CODING_SEL(cod), .POS_REF_BUFFER_EN(pbuf),
		.NEG_REF_BUFFER_EN(nbuf), .ANALOG_INPUT_BUFFER_EN(ibuf), .REFERENCE_SOURCE_SEL(rsel));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		pa   <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Request held until ready is seen high at a rising edge
		@(posedge clk);
		while (rdy !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, rdy}, 32'h1);
		rd = prd;
		re = err;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic step;
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		#100000;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk(ov, {14'h0, 1'b1, 11'h101, 6'h20});
		for (int i = 0; i < 16; i++) rchk(12'h040 + 12'(4 * i), 32'h8001);
		for (int i = 0; i < 8; i++) rchk(12'h080 + 12'(4 * i), 32'h1000);
		apb(1'b0, 12'h0a0, 32'h0);
		chk({re, rd[30:0]}, 32'h80000000);
		apb(1'b0, 12'h082, 32'h0);
		chk({re, rd[30:0]}, 32'h80000000);
		apb(1'b1, 12'h040, 32'hfc01);
		rchk(12'h040, 32'hf001);
		// Setup 7 drives channel 0 outputs
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h09c, {16'h0, sw[i]});
			rchk(12'h09c, {16'h0, sw[i] & 16'h1f30});
			repeat (2) @(negedge clk);
			chk(ov, {14'h0, 1'b1, 11'h101, sf[i]});
		end
		// Positive input number is not defined for sensor or reference
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h040, {16'h0, 6'h3c, rc[i]});
			repeat (2) @(negedge clk);
			chk(i > 5 ? ov & ~32'h3c00 : ov, {14'h0, 1'b1, rk[i], 6'h30});
		end
		for (int i = 1; i < 16; i++) apb(1'b1, 12'h040 + 12'(4 * i), i == 5 ? 32'h8043 : 32'h1);
		step;
		chk(ov, {10'h0, 4'h5, 1'b1, 11'h123, 6'h20});
		step;
		chk(ov & ~32'h3c00, {10'h0, 4'h0, 1'b1, 11'h400, 6'h30});
		apb(1'b1, 12'h040, 32'h0001);
		apb(1'b1, 12'h054, 32'h0001);
		repeat (2) @(negedge clk);
		chk({31'h0, any}, 32'h0);
		// Reset in mid-run restores the converter outputs and the channel 0 and setup 7 registers
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk(ov, {14'h0, 1'b1, 11'h101, 6'h20});
		rchk(12'h040, 32'h8001);
		rchk(12'h09c, 32'h1000);
		final_report;
	end
endmodule
`default_nettype wire
